// file: shared/csl_pkg.sv
package csl_pkg;

  // ----------------------------------------------------------------
  // Register locations
  // ----------------------------------------------------------------
  localparam logic [7:0] CSL_ADDR_VREG   = 8'h02;
  localparam logic [7:0] CSL_ADDR_ICHG   = 8'h04;
  localparam logic [7:0] CSL_ADDR_SPEC   = 8'h05;
  localparam logic [7:0] CSL_ADDR_SAFETY = 8'h06;
  localparam logic [7:0] CSL_ADDR_IND    = 8'h07;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CSL_RST_VREG   = 8'h0a;
  localparam logic [7:0] CSL_RST_ICHG   = 8'h01;
  localparam logic [7:0] CSL_RST_SPEC   = 8'h24;
  localparam logic [7:0] CSL_RST_SAFETY = 8'h40;
  localparam logic [7:0] CSL_RST_IND    = 8'h82;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CSL_VREG_LSB     = 2;
  localparam int CSL_ICHG_RST_BIT = 7;
  localparam int CSL_ICHG_LSB     = 3;
  localparam int CSL_SPEC_VIN_BIT = 6;
  localparam int CSL_SPEC_LOW_BIT = 5;
  localparam int CSL_SPEC_DPM_BIT = 4;
  localparam int CSL_SPEC_CD_BIT  = 3;
  localparam int CSL_SAFE_I_LSB   = 4;
  localparam int CSL_IND_CUR_LSB  = 6;
  localparam int CSL_IND_ZERO_BIT = 5;
  localparam int CSL_IND_MODE_BIT = 4;
  localparam int CSL_IND_ON_LSB   = 2;

  // Voltage limit code 0 sits 700 mV (35 steps of 20 mV) above the 3.5 V base
  localparam logic [6:0] CSL_VLIM_OFFSET = 7'h23;
  // 1.55 A at 68 mOhm is 37.4 mV + 10 steps of 6.8 mV
  localparam logic [3:0] CSL_VIN_ICAP    = 4'ha;

  // ----------------------------------------------------------------
  // Indicator timing
  // ----------------------------------------------------------------
  localparam int CSL_CLK_PERIOD_PS = 25000;
  localparam int CSL_MS_PS         = 1000000000;
  localparam int CSL_MS_CYCLES     = CSL_MS_PS / CSL_CLK_PERIOD_PS;
  localparam logic [11:0] CSL_ON_MS0  = 12'h00d;
  localparam logic [11:0] CSL_ON_MS1  = 12'h104;
  localparam logic [11:0] CSL_ON_MS2  = 12'h208;
  localparam logic [11:0] CSL_OFF_MS0 = 12'h186;
  localparam logic [11:0] CSL_OFF_MS1 = 12'h30c;
  localparam logic [11:0] CSL_OFF_MS2 = 12'h618;
  localparam logic [11:0] CSL_OFF_MS3 = 12'hc30;
  localparam logic [1:0]  CSL_ON_CONST = 2'h3;

  typedef enum logic [2:0] {
    CSL_IND_IDLE = 3'b001,
    CSL_IND_ON   = 3'b010,
    CSL_IND_OFF  = 3'b100
  } csl_ind_state_t;

endpackage

// file: hw/csl_regs.sv
`timescale 1ns/10ps

module csl_regs
  import csl_pkg::*;
#(
  parameter int MS_CYCLES = CSL_MS_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_batt_below_short,
  input  wire logic       i_safety_limit_reset_pin_n,
  input  wire logic       i_vin_present,
  input  wire logic       i_input_power_limiting_active,
  input  wire logic       i_charge_disable_pin,
  input  wire logic       i_charging_from_vin,
  input  wire logic       i_charging_active,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_valid,
  output logic      [5:0] o_eff_regulation_code,
  output logic      [3:0] o_eff_charge_current_code,
  output logic            o_reduced_charge_current_select,
  output logic      [2:0] o_termination_current_field,
  output logic      [2:0] o_special_charger_voltage_field,
  output logic            o_charger_reset,
  output logic            o_safety_locked,
  output logic            o_indicator_on,
  output logic      [1:0] o_indicator_current_field
);

  // Prescaler compare needs at least one cycle per millisecond
  if (MS_CYCLES < 1) begin : g_bad_ms_cycles
    $error("MS_CYCLES must be at least 1");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] vreg_q;
  logic [7:0] ichg_q;
  logic [7:0] spec_q;
  logic [7:0] safety_q;
  logic [7:0] ind_q;
  logic       lock_q;
  logic       slim_rst;
  logic       wr_safety;
  logic       chg_rst_req;

  assign slim_rst    = i_batt_below_short | ~i_safety_limit_reset_pin_n;
  assign wr_safety   = i_wr_en && (i_addr == CSL_ADDR_SAFETY);
  assign chg_rst_req = i_wr_en && (i_addr == CSL_ADDR_ICHG) && i_wr_data[CSL_ICHG_RST_BIT];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      vreg_q <= CSL_RST_VREG;
      ichg_q <= CSL_RST_ICHG;
      spec_q <= CSL_RST_SPEC;
      ind_q  <= CSL_RST_IND;
    end else if (i_wr_en) begin
      case (i_addr)
        CSL_ADDR_VREG: vreg_q <= i_wr_data;
        CSL_ADDR_ICHG: ichg_q <= {1'b0, i_wr_data[6:0]};
        CSL_ADDR_SPEC: spec_q <= {i_wr_data[7], 1'b0, i_wr_data[5], 2'b00,
                                  i_wr_data[2:0]};
        CSL_ADDR_IND:  ind_q  <= {i_wr_data[7:6], 1'b0, i_wr_data[4:0]};
        default: ;
      endcase
    end
  end

  // Safety limit has its own reset sources; a pin reset wins over a write
  always_ff @(posedge i_clk) begin
    if (i_srst || slim_rst) begin
      safety_q <= CSL_RST_SAFETY;
    end else if (wr_safety && !lock_q) begin
      safety_q <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || slim_rst) begin
      lock_q <= 1'b0;
    end else if (i_wr_en && !wr_safety) begin
      lock_q <= 1'b1;
    end
  end

  // Charger reset is write-only: one pulse, never stored
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_charger_reset <= 1'b0;
    end else begin
      o_charger_reset <= chg_rst_req;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      CSL_ADDR_VREG:   rd_mux = vreg_q;
      CSL_ADDR_ICHG:   rd_mux = ichg_q;
      CSL_ADDR_SPEC: begin
        rd_mux = spec_q;
        rd_mux[CSL_SPEC_VIN_BIT] = i_vin_present;
        rd_mux[CSL_SPEC_DPM_BIT] = i_input_power_limiting_active;
        rd_mux[CSL_SPEC_CD_BIT]  = i_charge_disable_pin;
      end
      CSL_ADDR_SAFETY: rd_mux = safety_q;
      CSL_ADDR_IND:    rd_mux = ind_q;
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Effective charge settings
  // ----------------------------------------------------------------
  logic [5:0] vprog;
  logic [6:0] vlim;
  logic [3:0] iprog;
  logic [3:0] ilim;
  logic [3:0] icap;
  logic [5:0] veff;
  logic [3:0] ieff;

  assign vprog = vreg_q[CSL_VREG_LSB +: 6];
  assign vlim  = CSL_VLIM_OFFSET + {3'b000, safety_q[3:0]};
  assign iprog = ichg_q[CSL_ICHG_LSB +: 4];
  assign ilim  = safety_q[CSL_SAFE_I_LSB +: 4];
  assign icap  = (i_charging_from_vin && (CSL_VIN_ICAP < ilim)) ? CSL_VIN_ICAP : ilim;
  assign veff  = ({1'b0, vprog} > vlim) ? vlim[5:0] : vprog;
  assign ieff  = (iprog > icap) ? icap : iprog;

  // Recomputed every cycle so any register change reaches the outputs next edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_eff_regulation_code           <= CSL_RST_VREG[CSL_VREG_LSB +: 6];
      o_eff_charge_current_code       <= CSL_RST_ICHG[CSL_ICHG_LSB +: 4];
      o_reduced_charge_current_select <= CSL_RST_SPEC[CSL_SPEC_LOW_BIT];
      o_termination_current_field     <= CSL_RST_ICHG[2:0];
      o_special_charger_voltage_field <= CSL_RST_SPEC[2:0];
      o_safety_locked                 <= 1'b0;
    end else begin
      o_eff_regulation_code           <= veff;
      o_eff_charge_current_code       <= ieff;
      o_reduced_charge_current_select <= spec_q[CSL_SPEC_LOW_BIT];
      o_termination_current_field     <= ichg_q[2:0];
      o_special_charger_voltage_field <= spec_q[2:0];
      o_safety_locked                 <= lock_q;
    end
  end

  // ----------------------------------------------------------------
  // Indicator blink timing
  // ----------------------------------------------------------------
  csl_ind_state_t st_q;
  logic [31:0]    pre_q;
  logic [11:0]    ms_q;
  logic           ms_tick;
  logic           ind_en;
  logic [1:0]     on_sel;
  logic [11:0]    on_ms;
  logic [11:0]    off_ms;

  assign ms_tick = (pre_q == 32'(MS_CYCLES - 1));
  assign on_sel  = ind_q[CSL_IND_ON_LSB +: 2];
  assign ind_en  = (ind_q[CSL_IND_CUR_LSB +: 2] != 2'b00)
                   && (ind_q[CSL_IND_MODE_BIT] || i_charging_active);

  always_comb begin
    case (on_sel)
      2'h0:    on_ms = CSL_ON_MS0;
      2'h1:    on_ms = CSL_ON_MS1;
      default: on_ms = CSL_ON_MS2;
    endcase
    case (ind_q[1:0])
      2'h0:    off_ms = CSL_OFF_MS0;
      2'h1:    off_ms = CSL_OFF_MS1;
      2'h2:    off_ms = CSL_OFF_MS2;
      default: off_ms = CSL_OFF_MS3;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || st_q == CSL_IND_IDLE || ms_tick) begin
      pre_q <= 32'h0;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= CSL_IND_IDLE;
      ms_q <= 12'h000;
    end else if (!ind_en) begin
      st_q <= CSL_IND_IDLE;
      ms_q <= 12'h000;
    end else begin
      case (st_q)
        CSL_IND_IDLE: begin
          st_q <= CSL_IND_ON;
          ms_q <= 12'h000;
        end
        CSL_IND_ON: begin
          if (on_sel == CSL_ON_CONST) begin
            ms_q <= 12'h000;
          end else if (ms_tick) begin
            if (ms_q + 12'h1 >= on_ms) begin
              st_q <= CSL_IND_OFF;
              ms_q <= 12'h000;
            end else begin
              ms_q <= ms_q + 12'h1;
            end
          end
        end
        CSL_IND_OFF: begin
          if (on_sel == CSL_ON_CONST) begin
            st_q <= CSL_IND_ON;
            ms_q <= 12'h000;
          end else if (ms_tick) begin
            if (ms_q + 12'h1 >= off_ms) begin
              st_q <= CSL_IND_ON;
              ms_q <= 12'h000;
            end else begin
              ms_q <= ms_q + 12'h1;
            end
          end
        end
        default: begin
          st_q <= CSL_IND_IDLE;
          ms_q <= 12'h000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_indicator_on            <= 1'b0;
      o_indicator_current_field <= CSL_RST_IND[CSL_IND_CUR_LSB +: 2];
    end else begin
      o_indicator_on            <= ind_en && (st_q == CSL_IND_ON);
      o_indicator_current_field <= ind_q[CSL_IND_CUR_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_STATUS_READ: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd_en && i_addr == CSL_ADDR_SPEC) |=> (o_rd_data[CSL_SPEC_VIN_BIT]
      == $past(i_vin_present) && o_rd_data[CSL_SPEC_DPM_BIT]
      == $past(i_input_power_limiting_active)))
    else $error("status bits wrong");

  AST_CD_LEVEL: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd_en && i_addr == CSL_ADDR_SPEC) |=>
      o_rd_data[CSL_SPEC_CD_BIT] == $past(i_charge_disable_pin))
    else $error("charge disable level wrong");

  AST_SLIM_RESET: assert property (@(posedge i_clk) disable iff (i_srst)
    (!i_safety_limit_reset_pin_n || i_batt_below_short) |=>
      (safety_q == CSL_RST_SAFETY && !lock_q))
    else $error("safety limit not reset");

  AST_LOCK_HOLDS: assert property (@(posedge i_clk) disable iff (i_srst)
    (lock_q && !slim_rst) |=> $stable(safety_q))
    else $error("locked safety limit changed");

  AST_LOCK_SET: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_wr_en && i_addr != CSL_ADDR_SAFETY && !slim_rst) |=> lock_q ##1 o_safety_locked)
    else $error("lock not set by other write");

  AST_VLIMIT: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 ({1'b0, o_eff_regulation_code} <= $past(vlim)
         && o_eff_regulation_code <= $past(vprog)))
    else $error("regulation code above limit");

  AST_ILIMIT: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 ($past(i_charging_from_vin) |-> o_eff_charge_current_code <= CSL_VIN_ICAP))
    else $error("adapter current cap exceeded");

  // Back-to-back reset writes may legally hold the pulse high
  AST_CHG_RESET: assert property (@(posedge i_clk) disable iff (i_srst)
    chg_rst_req |=> (o_charger_reset && !ichg_q[CSL_ICHG_RST_BIT])
      ##1 (!o_charger_reset || $past(chg_rst_req)))
    else $error("charger reset pulse wrong");

  AST_IND_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
    (!ind_q[CSL_IND_MODE_BIT] && !i_charging_active) [*2] |=> !o_indicator_on)
    else $error("indicator lit while not charging");

  AST_IND_CONST: assert property (@(posedge i_clk) disable iff (i_srst)
    (ind_en && on_sel == CSL_ON_CONST) [*3] |=> o_indicator_on)
    else $error("constant-on indicator dark");

  AST_SAFE_WRITE: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_safety && !lock_q && !slim_rst) |=> (safety_q == $past(i_wr_data)))
    else $error("unlocked safety write lost");

  AST_IND_DARK: assert property (@(posedge i_clk) disable iff (i_srst)
    (ind_q[CSL_IND_CUR_LSB +: 2] == 2'b00) |=> !o_indicator_on)
    else $error("indicator lit with zero current");

endmodule // csl_regs

// file: testbench/csl_host.sv
`timescale 1ns/10ps

module csl_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wr_data
);
  initial begin
    o_wr_en   = 1'b0;
    o_rd_en   = 1'b0;
    o_addr    = 8'h00;
    o_wr_data = 8'h00;
  end

  // Released lines flip so a stale byte never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr    = a;
    o_wr_data = d;
    o_wr_en   = 1'b1;
    @(negedge i_clk);
    o_wr_en   = 1'b0;
    o_addr    = ~a;
    o_wr_data = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_addr  = a;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d       = i_rd_data;
    v       = i_rd_valid;
  endtask
endmodule // csl_host

// file: testbench/csl_regs_tb.sv
`timescale 1ns/10ps

module csl_regs_tb;
  import csl_pkg::*;
  localparam int MS         = 2;
  // Longer than the longest blink phase at this prescale
  localparam int SPAN_MAX   = 8000;
  localparam int CONST_SPAN = 2000;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       wr_en, rd_en, rd_valid, bat_short, slr_n, vin, dpm, cd, cvin, chg;
  logic [7:0] addr, wr_data, rd_data;
  logic [5:0] eff_reg;
  logic [3:0] eff_cur;
  logic       red, crst, locked, ind_on;
  logic [2:0] term, spec;
  logic [1:0] ind_cur;
  int         err_count = 0;
  int         total_checks = 0;
  int         hi, lo;

  always #12.5 clk = ~clk;

  csl_host u_csl_host (.i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));

  csl_regs #(.MS_CYCLES(MS)) u_csl_regs (.i_clk(clk), .i_srst(srst), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data), .i_batt_below_short(bat_short),
    .i_safety_limit_reset_pin_n(slr_n), .i_vin_present(vin),
    .i_input_power_limiting_active(dpm), .i_charge_disable_pin(cd),
    .i_charging_from_vin(cvin), .i_charging_active(chg), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_eff_regulation_code(eff_reg),
    .o_eff_charge_current_code(eff_cur), .o_reduced_charge_current_select(red),
    .o_termination_current_field(term), .o_special_charger_voltage_field(spec),
    .o_charger_reset(crst), .o_safety_locked(locked), .o_indicator_on(ind_on),
    .o_indicator_current_field(ind_cur));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_csl_host.rd(a, d, v);
    chk(v, 1'b1);
    chk(d, e);
  endtask

  // Two edges: register then output flop
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic span(input logic lvl, input int lim, output int c);
    c = 0;
    while (ind_on === lvl && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask

  // First two phases may be cut by the write, so only the next pair is timed
  task automatic blink(input logic [7:0] cfg, input int on_len, input int off_len);
    int skip, t_on, t_off;
    u_csl_host.wr(CSL_ADDR_IND, cfg);
    rdchk(CSL_ADDR_IND, cfg & 8'hdf);
    chk(ind_cur, cfg[7:6]);
    span(1'b1, SPAN_MAX, skip);
    span(1'b0, SPAN_MAX, skip);
    span(1'b1, SPAN_MAX, t_on);
    span(1'b0, SPAN_MAX, t_off);
    chk(t_on, on_len);
    chk(t_off, off_len);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {bat_short, slr_n, vin, dpm, cd, cvin, chg} = 7'b0110100;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    rdchk(CSL_ADDR_SPEC, 8'h6c);
    {vin, dpm, cd} = 3'b010;
    rdchk(CSL_ADDR_SPEC, 8'h34);
    rdchk(CSL_ADDR_SAFETY, 8'h40);
    rdchk(CSL_ADDR_IND, 8'h82);
    rdchk(CSL_ADDR_ICHG, 8'h01);
    rdchk(CSL_ADDR_VREG, 8'h0a);
    chk({eff_reg, eff_cur, red}, {6'h02, 4'h0, 1'b1});
    chk({term, spec, locked, ind_cur, crst}, {3'h1, 3'h4, 1'b0, 2'h2, 1'b0});
    $display("test reset_values done");

    u_csl_host.wr(CSL_ADDR_SAFETY, 8'h11);
    u_csl_host.wr(CSL_ADDR_SAFETY, 8'h75);
    rdchk(CSL_ADDR_SAFETY, 8'h75);
    chk(locked, 1'b0);
    u_csl_host.wr(CSL_ADDR_VREG, 8'hfc);
    settle();
    chk(locked, 1'b1);
    chk(eff_reg, 6'h28);
    rdchk(CSL_ADDR_VREG, 8'hfc);
    u_csl_host.wr(CSL_ADDR_SAFETY, 8'h00);
    rdchk(CSL_ADDR_SAFETY, 8'h75);
    u_csl_host.wr(CSL_ADDR_ICHG, 8'hb8);
    chk(crst, 1'b1);
    @(negedge clk);
    chk(crst, 1'b0);
    settle();
    chk(eff_cur, 4'h7);
    chk(term, 3'h0);
    rdchk(CSL_ADDR_ICHG, 8'h38);
    $display("test safety_lock done");

    slr_n = 1'b0;
    repeat (2) @(negedge clk);
    slr_n = 1'b1;
    settle();
    chk(locked, 1'b0);
    rdchk(CSL_ADDR_SAFETY, 8'h40);
    u_csl_host.wr(CSL_ADDR_IND, 8'h82);
    u_csl_host.wr(CSL_ADDR_SAFETY, 8'hff);
    rdchk(CSL_ADDR_SAFETY, 8'h40);
    settle();
    chk({eff_reg, eff_cur}, {6'h23, 4'h4});
    $display("test reset_pin done");

    bat_short = 1'b1;
    repeat (2) @(negedge clk);
    bat_short = 1'b0;
    u_csl_host.wr(CSL_ADDR_SAFETY, 8'hff);
    u_csl_host.wr(CSL_ADDR_ICHG, 8'h78);
    u_csl_host.wr(CSL_ADDR_SPEC, 8'h03);
    u_csl_host.wr(CSL_ADDR_SAFETY, 8'h00);
    settle();
    rdchk(CSL_ADDR_SAFETY, 8'hff);
    chk({eff_reg, eff_cur}, {6'h32, 4'hf});
    chk({red, spec}, {1'b0, 3'h3});
    cvin = 1'b1;
    settle();
    chk(eff_cur, 4'ha);
    rdchk(CSL_ADDR_SPEC, 8'h13);
    rdchk(8'h03, 8'h00);
    $display("test short_reset done");

    blink(8'h70, 13 * MS, 390 * MS);
    blink(8'hd7, 260 * MS, 3120 * MS);
    blink(8'h99, 520 * MS, 780 * MS);
    blink(8'h52, 13 * MS, 1560 * MS);
    u_csl_host.wr(CSL_ADDR_IND, 8'h5c);
    settle();
    span(1'b1, CONST_SPAN, hi);
    chk(hi, CONST_SPAN);
    u_csl_host.wr(CSL_ADDR_IND, 8'h1c);
    settle();
    chk({ind_on, ind_cur}, {1'b0, 2'h0});
    u_csl_host.wr(CSL_ADDR_IND, 8'h4c);
    settle();
    span(1'b0, CONST_SPAN, lo);
    chk(lo, CONST_SPAN);
    chg = 1'b1;
    repeat (4) @(negedge clk);
    chk(ind_on, 1'b1);
    $display("test indicator done");
    conclude();
  end
endmodule // csl_regs_tb
